/* rtl/serializer_pkg.sv */
// Constants, field layout and state types shared by the 16-to-1 DDR serializer.
package serializer_pkg;
    localparam int LANE_COUNT = 16;
    localparam int ADDR_W = 4;
    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_LANES = 4'h8;
    // Control register field positions.
    localparam int CTRL_W = 5;
    localparam int CTRL_BIT_ORDER = 0;
    localparam int CTRL_FWD_DISABLE = 1;
    localparam int CTRL_PHASE_LO = 2;
    localparam int CTRL_PHASE_HI = 3;
    localparam int CTRL_SOFT_RESET = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    // Status register field positions.
    localparam int STAT_DIV_RESET = 4;
    localparam int STAT_WORD_CLK = 5;
    // Sampling clock shift in bit slots, indexed by {phase_select_hi, phase_select_lo}.
    localparam logic [3:0] PHASE_SHIFT_90 = 4'h4;
    localparam logic [3:0] PHASE_SHIFT_180 = 4'h8;
    localparam logic [3:0] PHASE_SHIFT_270 = 4'hc;
    localparam logic [3:0] PHASE_SHIFT_0 = 4'h0;
    // Divider and bit slot counts.
    localparam logic [3:0] LAST_BIT_IDX = 4'hf;
    localparam logic [2:0] DIV_PRESET = 3'h0;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [0:0] {WR_COLLECT = 1'b0, WR_RESPOND = 1'b1} wr_state_t;
    typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_RESPOND = 1'b1} rd_state_t;
endpackage

/* rtl/ddr_serializer_16to1.sv */
// Sixteen-lane to one-line DDR serializer with divider, clock outputs and AXI4-Lite control.
//
// Functional notes
// [R01] Sixteen parallel lanes at one sixteenth rate merge into one full-rate serial line.
// [R02] The outside supplies the half-rate clock feeding both the forwarded clock and divider; the design instead derives it by toggling on every aclk.
// [R03] Divider is three divide-by-two stages; every stage output feeds the serializer tree.
// [R04] Last divider stage gives the word-rate clock driving the sampling clock output.
// [R05] Asserted divider reset presets all divider stages to zero, aligning several devices.
// [R06] Incoming divider reset is retimed on the half-rate clock falling edge.
// [R07] Whole sixteen-bit word is captured on the word-rate clock falling edge.
// [R08] A captured word starts leaving about one word-rate period after capture.
// [R09] Bit order low sends lane 0 first; high sends lane 15 first.
// [R10] Forwarded clock disable low drives the half-rate clock out; high turns it off.
// [R11] Phase selects 00, 01, 10, 11 give 90, 180, 270 and 0 degrees.
// [R12] Forwarded half-rate clock travels phase-matched with data, one bit per clock edge.
// [R13] Remaining lanes follow in strict ascending or descending order, one per clock edge.
`timescale 1ns/1ns
module ddr_serializer_16to1
    import serializer_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [LANE_COUNT-1:0] parallel_lane_inputs,
    input wire logic divider_reset_in,
    output logic serial_data_out,
    output logic forwarded_clock_out,
    output logic forwarded_clock_oe,
    output logic sampling_clock_out
);

    // True for the offsets that hold a register.
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
        addr_mapped = (addr == ADDR_CTRL) || (addr == ADDR_STATUS) || (addr == ADDR_LANES);
    endfunction

    // Sampling clock shift for a phase select pair.
    function automatic logic [3:0] phase_shift(input logic [1:0] sel);
        case (sel)
            2'h0: phase_shift = PHASE_SHIFT_90;
            2'h1: phase_shift = PHASE_SHIFT_180;
            2'h2: phase_shift = PHASE_SHIFT_270;
            default: phase_shift = PHASE_SHIFT_0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Serializer state.

    logic half_clk_reg, half_clk_next;
    logic [2:0] div_reg, div_next;
    logic rst_sync1_reg, rst_sync2_reg, rst_retimed_reg, rst_retimed_next;
    logic [LANE_COUNT-1:0] lane_sync1_reg, lane_sync2_reg;
    logic [LANE_COUNT-1:0] hold_word_reg, hold_word_next;
    logic [LANE_COUNT-1:0] out_word_reg, out_word_next;
    logic order_reg, order_next;
    logic serial_next, fwd_clk_next, fwd_oe_next, samp_clk_next;
    logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
    logic [3:0] bit_idx_reg, bit_idx_next, samp_phase;
    logic word_edge;

    assign bit_idx_reg = {div_reg, half_clk_reg};
    // The word clock falls as the bit index wraps from its last slot to zero.
    assign word_edge = (bit_idx_reg == LAST_BIT_IDX) && !rst_retimed_reg;

    // One aclk cycle stands for one half period of the half-rate clock: one serial bit slot.
    always_comb begin
        half_clk_next = !half_clk_reg; // see [R02]
        // The divider stages advance together on the half-rate falling edge.
        div_next = half_clk_reg ? div_reg + 3'h1 : div_reg; // see [R03]
        if (rst_retimed_reg) begin
            div_next = DIV_PRESET; // see [R05]
        end
        // Retiming only on the falling edge keeps reset release aligned across devices.
        rst_retimed_next = rst_retimed_reg;
        if (half_clk_reg) begin
            rst_retimed_next = rst_sync2_reg || ctrl_reg[CTRL_SOFT_RESET]; // see [R06]
        end
        bit_idx_next = {div_next, half_clk_next};
        hold_word_next = hold_word_reg;
        out_word_next = out_word_reg;
        order_next = order_reg;
        if (word_edge) begin
            hold_word_next = lane_sync2_reg; // see [R07]
            out_word_next = hold_word_reg; // see [R08]
            // Order is latched per word so a control write never splits a word.
            order_next = ctrl_reg[CTRL_BIT_ORDER]; // see [R09]
        end
        // Each slot sends one lane; the index runs up, or down when reversed.
        serial_next = order_next ? out_word_next[LAST_BIT_IDX - bit_idx_next]
                                 : out_word_next[bit_idx_next]; // see [R01] see [R13]
        fwd_oe_next = !ctrl_reg[CTRL_FWD_DISABLE]; // see [R10]
        fwd_clk_next = fwd_oe_next ? half_clk_next : 1'b0; // see [R12]
        samp_phase = bit_idx_next - phase_shift({ctrl_reg[CTRL_PHASE_HI], ctrl_reg[CTRL_PHASE_LO]}); // see [R11]
        samp_clk_next = samp_phase[3]; // see [R04]
    end

    // Lane and reset pins pass two flip-flops before any logic reads them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            half_clk_reg <= 1'b0;
            div_reg <= DIV_PRESET;
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
            rst_retimed_reg <= 1'b0;
            lane_sync1_reg <= WORD_RESET;
            lane_sync2_reg <= WORD_RESET;
            hold_word_reg <= WORD_RESET;
            out_word_reg <= WORD_RESET;
            order_reg <= 1'b0;
            serial_data_out <= 1'b0;
            forwarded_clock_out <= 1'b0;
            forwarded_clock_oe <= 1'b0;
            sampling_clock_out <= 1'b0;
        end else begin
            half_clk_reg <= half_clk_next;
            div_reg <= div_next;
            rst_sync1_reg <= divider_reset_in;
            rst_sync2_reg <= rst_sync1_reg;
            rst_retimed_reg <= rst_retimed_next;
            lane_sync1_reg <= parallel_lane_inputs;
            lane_sync2_reg <= lane_sync1_reg;
            hold_word_reg <= hold_word_next;
            out_word_reg <= out_word_next;
            order_reg <= order_next;
            serial_data_out <= serial_next;
            forwarded_clock_out <= fwd_clk_next;
            forwarded_clock_oe <= fwd_oe_next;
            sampling_clock_out <= samp_clk_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave.

    wr_state_t wr_state_reg, wr_state_next;
    rd_state_t rd_state_reg, rd_state_next;
    logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
    logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next, wr_addr;
    logic [31:0] w_data_reg, w_data_next, wr_data;
    logic [3:0] w_strb_reg, w_strb_next, wr_strb;
    logic [1:0] bresp_next, rresp_next;
    logic [31:0] rdata_next;
    logic aw_take, w_take, awready_next, wready_next, arready_next;

    // Address and data are taken in either order; the response follows the second.
    always_comb begin
        aw_take = s_axi_awvalid && s_axi_awready;
        w_take = s_axi_wvalid && s_axi_wready;
        aw_full_next = aw_full_reg || aw_take;
        w_full_next = w_full_reg || w_take;
        aw_addr_next = aw_take ? s_axi_awaddr : aw_addr_reg;
        w_data_next = w_take ? s_axi_wdata : w_data_reg;
        w_strb_next = w_take ? s_axi_wstrb : w_strb_reg;
        wr_addr = aw_addr_next;
        wr_data = w_data_next;
        wr_strb = w_strb_next;
        wr_state_next = wr_state_reg;
        bresp_next = s_axi_bresp;
        ctrl_next = ctrl_reg;
        case (wr_state_reg)
            WR_COLLECT: begin
                if (aw_full_next && w_full_next) begin
                    wr_state_next = WR_RESPOND;
                    aw_full_next = 1'b0;
                    w_full_next = 1'b0;
                    bresp_next = addr_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
                    // Status and lane words are read-only; writes there are dropped.
                    if (wr_addr == ADDR_CTRL && wr_strb[0]) begin
                        ctrl_next = wr_data[CTRL_W-1:0];
                    end
                end
            end
            WR_RESPOND: begin
                if (s_axi_bready) begin
                    wr_state_next = WR_COLLECT;
                end
            end
            default: wr_state_next = WR_COLLECT;
        endcase
        awready_next = !aw_full_next && (wr_state_next == WR_COLLECT);
        wready_next = !w_full_next && (wr_state_next == WR_COLLECT);
    end

    // Reads answer one cycle after the address is taken.
    always_comb begin
        rd_state_next = rd_state_reg;
        rdata_next = s_axi_rdata;
        rresp_next = s_axi_rresp;
        case (rd_state_reg)
            RD_IDLE: begin
                if (s_axi_arvalid) begin
                    rd_state_next = RD_RESPOND;
                    rresp_next = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
                    case (s_axi_araddr)
                        ADDR_CTRL: rdata_next = {27'h0, ctrl_reg};
                        ADDR_STATUS: rdata_next = {26'h0, div_reg[2], rst_retimed_reg, bit_idx_reg};
                        ADDR_LANES: rdata_next = {16'h0000, hold_word_reg};
                        default: rdata_next = 32'h00000000;
                    endcase
                end
            end
            RD_RESPOND: begin
                if (s_axi_rready) begin
                    rd_state_next = RD_IDLE;
                end
            end
            default: rd_state_next = RD_IDLE;
        endcase
        arready_next = (rd_state_next == RD_IDLE);
    end

    // Bus registers; ready outputs come from flip-flops.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_reg <= WR_COLLECT;
            rd_state_reg <= RD_IDLE;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            ctrl_reg <= CTRL_RESET;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
        end else begin
            wr_state_reg <= wr_state_next;
            rd_state_reg <= rd_state_next;
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            aw_addr_reg <= aw_addr_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            ctrl_reg <= ctrl_next;
            s_axi_awready <= awready_next;
            s_axi_wready <= wready_next;
            s_axi_bvalid <= (wr_state_next == WR_RESPOND);
            s_axi_bresp <= bresp_next;
            s_axi_arready <= arready_next;
            s_axi_rvalid <= (rd_state_next == RD_RESPOND);
            s_axi_rresp <= rresp_next;
            s_axi_rdata <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence word_wrap_s;
        word_edge;
    endsequence

    sequence next_wrap_s;
        (bit_idx_reg == LAST_BIT_IDX);
    endsequence

    // Stage chain wraps to zero after the last slot.
    a_divider_wrap: assert property (word_edge |=> bit_idx_reg == 4'h0) // see [R03]
        else $error("divider did not wrap to zero");
    // The word clock rises halfway through the word.
    a_word_clock_rise: assert property ((bit_idx_reg == 4'h7 && !rst_retimed_reg) |=> div_reg[2]) // see [R04]
        else $error("word clock did not rise at mid word");
    a_divider_preset: assert property (rst_retimed_reg |=> div_reg == DIV_PRESET) // see [R05]
        else $error("divider not preset while reset active");
    a_reset_retime: assert property ($changed(rst_retimed_reg) |-> $past(half_clk_reg)) // see [R06]
        else $error("reset changed off the falling edge");
    a_word_capture: assert property (word_wrap_s |=> hold_word_reg == $past(lane_sync2_reg)) // see [R07]
        else $error("word not captured at word clock fall");
    a_word_latency: assert property (word_wrap_s ##16 next_wrap_s |=> out_word_reg == $past(lane_sync2_reg, 17)) // see [R08]
        else $error("word not sent one word period after capture");
    a_first_bit: assert property (word_wrap_s |=> serial_data_out == (order_reg ? out_word_reg[15] : out_word_reg[0])) // see [R09]
        else $error("wrong first lane for bit order");
    a_fwd_disable: assert property (ctrl_reg[CTRL_FWD_DISABLE] |=> (!forwarded_clock_oe && !forwarded_clock_out)) // see [R10]
        else $error("forwarded clock active while disabled");
    a_phase_zero: assert property ((ctrl_reg[CTRL_PHASE_HI +: 1] && ctrl_reg[CTRL_PHASE_LO] && $stable(ctrl_reg))
        |-> sampling_clock_out == div_reg[2]) // see [R11]
        else $error("zero degree sampling clock misaligned");
    // The driver must already have been on a cycle, or the first enabled edge has no earlier level to flip.
    a_fwd_toggle: assert property ((!ctrl_reg[CTRL_FWD_DISABLE] && $past(!ctrl_reg[CTRL_FWD_DISABLE])
        && $past(forwarded_clock_oe))
        |-> forwarded_clock_out == half_clk_reg && forwarded_clock_out != $past(forwarded_clock_out)) // see [R12]
        else $error("forwarded clock not toggling with data");
    a_bit_sequence: assert property (serial_data_out == (order_reg ? out_word_reg[LAST_BIT_IDX - bit_idx_reg]
        : out_word_reg[bit_idx_reg])) // see [R13]
        else $error("serial bit out of lane order");

endmodule

/* verification/lane_partner.sv */
// Far-side model: parallel word source feeding the lanes and a serial receiver behind the line.
`timescale 1ns/1ns
module lane_partner
    import serializer_pkg::*;
(
    input wire logic aclk,
    input wire logic [LANE_COUNT-1:0] tx_word,
    output logic [LANE_COUNT-1:0] parallel_lane_inputs,
    input wire logic serial_data_out,
    input wire logic forwarded_clock_out,
    output logic [LANE_COUNT-1:0] rx_word,
    output logic [LANE_COUNT-1:0] rx_clock
);
    ////////////////////////////////////////////////////////////////////////////
    // The source changes its lanes just after a rising edge, one word held per call.
    always @(posedge aclk) begin
        parallel_lane_inputs <= tx_word;
    end

    ////////////////////////////////////////////////////////////////////////////
    // The receiver samples mid-slot, so the newest bit lands at the top and slot 0 ends at bit 0.
    // Keeping the forwarded clock beside the data shows whether each bit sits on its own edge.
    always @(negedge aclk) begin
        rx_word <= {serial_data_out, rx_word[LANE_COUNT-1:1]};
        rx_clock <= {forwarded_clock_out, rx_clock[LANE_COUNT-1:1]};
    end
endmodule

/* verification/testbench.sv */
// Self-checking bench for the 16-to-1 DDR serializer with its far-side model.
`timescale 1ns/1ns
module testbench
    import serializer_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, divider_reset_in = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [15:0] tx_word = 16'h0000;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    logic serial_data_out, forwarded_clock_out, forwarded_clock_oe, sampling_clock_out;
    logic [15:0] parallel_lane_inputs, rx_word, rx_clock;
    int error_cnt = 0;
    int num_checks = 0;

    ////////////////////////////////////////////////////////////////////////////
    // The bench clock is the bit-slot clock; the design derives the half-rate clock from it.
    initial begin
        forever #10 aclk = ~aclk;
    end

    ddr_serializer_16to1 i_ddr_serializer_16to1 (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .parallel_lane_inputs(parallel_lane_inputs),
        .divider_reset_in(divider_reset_in), .serial_data_out(serial_data_out),
        .forwarded_clock_out(forwarded_clock_out), .forwarded_clock_oe(forwarded_clock_oe),
        .sampling_clock_out(sampling_clock_out));

    lane_partner i_lane_partner (.aclk(aclk), .tx_word(tx_word), .parallel_lane_inputs(parallel_lane_inputs),
        .serial_data_out(serial_data_out), .forwarded_clock_out(forwarded_clock_out), .rx_word(rx_word),
        .rx_clock(rx_clock));

    ////////////////////////////////////////////////////////////////////////////
    // Reporting and shared helpers.
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic timed_out();
        error_cnt++;
        end_sim();
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] rev(input logic [15:0] v);
        logic [15:0] r;
        for (int i = 0; i < 16; i++) r[i] = v[15 - i];
        return r;
    endfunction

    // Each channel drops its valid at the edge that takes it; the wait is bounded.
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
            if (n > 50) timed_out();
        end
    endtask

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
            if (n > 50) timed_out();
        end
    endtask

    // Returns at the mid-slot sample where the sampling clock has just fallen.
    task automatic wait_fall();
        logic p;
        p = 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(negedge aclk);
            if (p === 1'b1 && sampling_clock_out === 1'b0) return;
            p = sampling_clock_out;
        end
        timed_out();
    endtask

    task automatic nbits(input int n);
        repeat (n) @(negedge aclk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_regs();
        axi_read(ADDR_CTRL, rd, resp);
        check({rd[4:0], resp}, {CTRL_RESET, RESP_OKAY});
        check(forwarded_clock_oe, 1'b1);
        axi_read(4'hc, rd, resp);
        check(rd, 32'h0);
        check(resp, RESP_SLVERR);
        axi_write(4'hc, 32'h1f, resp);
        check(resp, RESP_SLVERR);
        axi_write(ADDR_STATUS, 32'h0, resp);
        check(resp, RESP_OKAY);
        // A control write with its low byte lane masked must leave the forwarded clock on.
        s_axi_wstrb <= 4'he;
        axi_write(ADDR_CTRL, 32'h02, resp);
        s_axi_wstrb <= 4'hf;
        check(resp, RESP_OKAY);
        axi_read(ADDR_CTRL, rd, resp);
        check(rd, {27'h0, CTRL_RESET});
        check(forwarded_clock_oe, 1'b1);
    endtask

    // Disabling the forwarded clock must silence it and drop its enable.
    task automatic t_fwd_off();
        logic acc;
        acc = 1'b0;
        axi_write(ADDR_CTRL, 32'h0e, resp);
        repeat (4) @(negedge aclk);
        for (int i = 0; i < 8; i++) begin
            @(negedge aclk);
            acc = acc | forwarded_clock_out | forwarded_clock_oe;
        end
        check(acc, 1'b0);
        axi_write(ADDR_CTRL, 32'h0c, resp);
        repeat (3) @(posedge aclk);
        check(forwarded_clock_oe, 1'b1);
    endtask

    // Zero-degree phase marks slot 0; a word change shows up two frames on.
    task automatic t_serial(input logic order, input logic [15:0] w1, input logic [15:0] w2);
        axi_write(ADDR_CTRL, {28'h0, 2'b11, 1'b0, order}, resp);
        tx_word <= w1;
        repeat (48) @(posedge aclk);
        wait_fall();
        tx_word <= w2;
        nbits(15);
        check(rx_word, order ? rev(w1) : w1);
        check(rx_clock, 16'haaaa);
        nbits(16);
        check(rx_word, order ? rev(w1) : w1);
        nbits(16);
        check(rx_word, order ? rev(w2) : w2);
        axi_read(ADDR_LANES, rd, resp);
        check(rd, {16'h0, w2});
    endtask

    // Lane 0 alone marks slot 0; the sampling clock must fall exactly shift slots later.
    task automatic t_phase(input logic [1:0] code);
        logic p;
        int n, seen;
        axi_write(ADDR_CTRL, {28'h0, code, 2'b00}, resp);
        repeat (40) @(negedge aclk);
        p = sampling_clock_out;
        n = -1;
        seen = -1;
        for (int i = 0; i < 48; i++) begin
            @(negedge aclk);
            if (n < 0 && serial_data_out === 1'b1) n = 0;
            else if (n >= 0) n++;
            if (n >= 0 && seen < 0 && p === 1'b1 && sampling_clock_out === 1'b0) seen = n;
            p = sampling_clock_out;
        end
        check(32'(seen), 32'(((code + 1) * 4) % 16));
    endtask

    // Both the pin and the control bit must hold every divider stage at zero.
    task automatic t_div_reset();
        logic acc;
        acc = 1'b0;
        axi_write(ADDR_CTRL, 32'h0c, resp);
        divider_reset_in <= 1'b1;
        repeat (10) @(negedge aclk);
        for (int i = 0; i < 16; i++) begin
            @(negedge aclk);
            acc = acc | sampling_clock_out;
        end
        check(acc, 1'b0);
        axi_read(ADDR_STATUS, rd, resp);
        check(rd[5:1], 5'h08);
        divider_reset_in <= 1'b0;
        repeat (12) @(posedge aclk);
        axi_read(ADDR_STATUS, rd, resp);
        check(rd[4], 1'b0);
        axi_write(ADDR_CTRL, 32'h1c, resp);
        repeat (6) @(posedge aclk);
        axi_read(ADDR_STATUS, rd, resp);
        check(rd[5:1], 5'h08);
        axi_write(ADDR_CTRL, 32'h0c, resp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset for 20 cycles, then every scenario in turn.
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_fwd_off();
        t_serial(1'b0, 16'h1ca5, 16'h8e31);
        t_serial(1'b1, 16'h8e31, 16'h0f3c);
        tx_word <= 16'h0001;
        for (int c = 0; c < 4; c++) t_phase(2'(c));
        t_div_reset();
        t_serial(1'b0, 16'h0f3c, 16'h5a96);
        end_sim();
    end
endmodule
